// file: logic/ptu_defines.vh
// Purpose: Shared constants of the six-channel pulse timer unit.
// Assumes: Included by bare name from the timer design files.
// Notes: Definitions only; no logic lives here.
`ifndef PTU_DEFINES_VH
`define PTU_DEFINES_VH

// Geometry of the unit.
`define PTU_CNT_W 16
`define PTU_NCH 6
`define PTU_NREG 16
`define PTU_PRESC_W 12
`define PTU_CNT_MAX 16'hffff
`define PTU_CNT_ZERO 16'h0000
`define PTU_CNT_RST 16'h0000
`define PTU_GR_RST 16'hffff

// Module stop is asserted out of reset.
`define PTU_STOP_RST 1'b1

// Access selector: 0 to 3 pick a general register, 4 picks the counter.
`define PTU_SEL_CNT 3'h4

// Counter clear selector: 0 none, 1 to 4 registers A to D, 5 group clear.
`define PTU_CLR_NONE 3'h0
`define PTU_CLR_SYNC 3'h5

// Compare-match pin action.
`define PTU_ACT_NONE 2'h0
`define PTU_ACT_LOW 2'h1
`define PTU_ACT_HIGH 2'h2
`define PTU_ACT_TOG 2'h3

// Capture edge field: bit 0 rising, bit 1 falling, both for both edges.
`define PTU_EDGE_RISE_BIT 0
`define PTU_EDGE_FALL_BIT 1

// Count source codes: 0..6 divide by 1,4,16,64,256,1024,4096; 8..b pins a..d; f none.
`define PTU_SRC_EXT_BIT 3
`define PTU_SRC_NONE 4'hf

// Per-channel source maps, one nibble per selector value, selector 0 lowest.
`define PTU_MAP_CH0 32'hba983210
`define PTU_MAP_CH1 32'hf9843210
`define PTU_MAP_CH2 32'hf9853210
`define PTU_MAP_CH3 32'h86543210
`define PTU_MAP_CH4 32'hfa853210
`define PTU_MAP_CH5 32'hfa843210

`endif

// file: logic/ptu_clk_src.v
// Purpose: Count-clock selection and up/down decision for one timer channel.
// Assumes: All inputs are synchronous single-cycle ticks or sampled levels.
// Notes: Purely combinational; the channel counter applies the result.
`timescale 1ns/1ns
`include "ptu_defines.vh"

module ptu_clk_src #(
  parameter [31:0] SRC_MAP = `PTU_MAP_CH0
) (
  input wire [2:0] clk_sel_in,
  input wire [6:0] presc_tick_in,
  input wire [3:0] ext_rise_in,
  input wire phase_en_in,
  input wire pa_in,
  input wire pb_in,
  input wire pa_q_in,
  input wire pb_q_in,
  input wire casc_en_in,
  input wire casc_up_in,
  input wire casc_dn_in,
  output reg up_out,
  output reg dn_out
);

  reg [3:0] code;
  reg tick;
  reg pa_r_e;
  reg pa_f_e;
  reg pb_r_e;
  reg pb_f_e;

  // Cascade beats phase counting, which beats the selected source.
  always @* begin
    code = SRC_MAP[{clk_sel_in, 2'b00} +: 4];
    if (code == `PTU_SRC_NONE) begin
      tick = 1'b0;
    end else if (code[`PTU_SRC_EXT_BIT]) begin
      tick = ext_rise_in[code[1:0]];
    end else begin
      tick = presc_tick_in[code[2:0]];
    end
    pa_r_e = pa_in & ~pa_q_in;
    pa_f_e = ~pa_in & pa_q_in;
    pb_r_e = pb_in & ~pb_q_in;
    pb_f_e = ~pb_in & pb_q_in;
    if (casc_en_in) begin
      up_out = casc_up_in;
      dn_out = casc_dn_in;
    end else if (phase_en_in) begin
      // Every edge of either phase counts; direction from the other phase.
      up_out = (pa_r_e & ~pb_in) | (pa_f_e & pb_in) |
               (pb_r_e & pa_in) | (pb_f_e & ~pa_in);
      dn_out = (pa_r_e & pb_in) | (pa_f_e & ~pb_in) |
               (pb_r_e & ~pa_in) | (pb_f_e & pa_in);
    end else begin
      up_out = tick;
      dn_out = 1'b0;
    end
  end

endmodule

// file: logic/pulse_timer_unit.v
// Purpose: Six-channel 16-bit timer pulse unit with compare, capture and counting modes.
// Assumes: Pins and control bits are synchronous to ref_clk_in; control is plain ports.
// Notes: General registers are indexed 0..15: ch0 0-3, ch1 4-5, ch2 6-7, ch3 8-11,
// ch4 12-13, ch5 14-15. Events are registered and pulse for one cycle.
`timescale 1ns/1ns
`include "ptu_defines.vh"

module pulse_timer_unit (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire module_stop_in,
  input wire wr_en_in,
  input wire [2:0] wr_chan_in,
  input wire [2:0] wr_sel_in,
  input wire [15:0] wr_data_in,
  input wire [2:0] rd_chan_in,
  input wire [2:0] rd_sel_in,
  output reg [15:0] rd_data_out,
  input wire [17:0] clk_sel_in,
  input wire [17:0] clr_sel_in,
  input wire [5:0] sync_en_in,
  input wire [5:0] pwm_en_in,
  input wire [1:0] buf_en_in,
  input wire [3:0] phase_en_in,
  input wire [1:0] cascade_en_in,
  input wire [15:0] capture_en_in,
  input wire [31:0] out_act_in,
  input wire [31:0] cap_edge_in,
  input wire [3:0] ext_clock_pin_in,
  input wire [15:0] cc_pin_in,
  output wire [15:0] cc_pin_out,
  output wire [15:0] cc_pin_oe_out,
  output wire [15:0] cc_irq_out,
  output wire [5:0] ovf_irq_out,
  output wire [3:0] unf_irq_out,
  output wire [5:0] dma_req_out,
  output wire [7:0] ppg_trig_out,
  output wire [5:0] adc_trig_out
);

  // Channel that owns a general register.
  function [2:0] ch_of;
    input integer j;
    begin
      if (j < 4) ch_of = 3'h0;
      else if (j < 6) ch_of = 3'h1;
      else if (j < 8) ch_of = 3'h2;
      else if (j < 12) ch_of = 3'h3;
      else if (j < 14) ch_of = 3'h4;
      else ch_of = 3'h5;
    end
  endfunction

  // First register index of a channel.
  function integer base_of;
    input integer k;
    begin
      if (k == 0) base_of = 0;
      else if (k == 1) base_of = 4;
      else if (k == 2) base_of = 6;
      else if (k == 3) base_of = 8;
      else if (k == 4) base_of = 12;
      else base_of = 14;
    end
  endfunction

  reg stop_r;
  reg [`PTU_PRESC_W-1:0] presc_r;
  reg [3:0] ext_q_r;
  reg [15:0] rd_nxt;
  wire run = ~stop_r;
  wire [6:0] presc_tick;
  wire [3:0] ext_rise;
  wire [5:0] up_w;
  wire [5:0] dn_w;
  wire [5:0] tick_w;
  wire [5:0] ovf_w;
  wire [5:0] unf_w;
  wire [5:0] own_clr_w;
  wire [5:0] unf_r_w;
  wire [15:0] match_w;
  wire [15:0] cap_w;
  wire [15:0] clr_hit_w;
  wire [15:0] ev_r_w;
  wire [255:0] gr_flat;
  wire [95:0] cnt_flat;
  wire grp_clr;
  wire wr_sync;
  integer i;

  // Module stop follows its input, but holds the unit halted from reset.
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_r <= `PTU_STOP_RST;
      presc_r <= {`PTU_PRESC_W{1'b0}};
      ext_q_r <= 4'h0;
    end else begin
      stop_r <= module_stop_in;
      presc_r <= run ? presc_r + 12'h001 : presc_r;
      ext_q_r <= ext_clock_pin_in;
    end
  end

  // Prescaler taps fire on the cycle the low bits are all ones.
  assign presc_tick[0] = run;
  assign presc_tick[1] = run & (&presc_r[1:0]);
  assign presc_tick[2] = run & (&presc_r[3:0]);
  assign presc_tick[3] = run & (&presc_r[5:0]);
  assign presc_tick[4] = run & (&presc_r[7:0]);
  assign presc_tick[5] = run & (&presc_r[9:0]);
  assign presc_tick[6] = run & (&presc_r[11:0]);
  assign ext_rise = {4{run}} & ext_clock_pin_in & ~ext_q_r;

  // A write to any synchronised counter reaches all of them.
  assign wr_sync = (wr_chan_in < 3'h6) ? sync_en_in[wr_chan_in] : 1'b0;
  // Any synchronised channel that clears itself clears every group member whose clear selector picks group clear.
  assign grp_clr = |(own_clr_w & sync_en_in);

  genvar k;
  genvar j;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_ch
      localparam [31:0] MAP = (k == 0) ? `PTU_MAP_CH0 : (k == 1) ? `PTU_MAP_CH1 :
                              (k == 2) ? `PTU_MAP_CH2 : (k == 3) ? `PTU_MAP_CH3 :
                              (k == 4) ? `PTU_MAP_CH4 : `PTU_MAP_CH5;
      localparam integer B = base_of(k);
      localparam integer N = (k == 0 || k == 3) ? 4 : 2;
      localparam integer PI = (k == 1) ? 0 : (k == 2) ? 1 : (k == 4) ? 2 : 3;
      localparam integer PA = (k == 2 || k == 4) ? 2 : 0;
      reg [15:0] cnt_r;
      reg ovf_r;
      reg unf_r;
      wire clr;
      wire cnt_wr;
      wire [2:0] csel = clr_sel_in[3*k +: 3];
      // Only channels 2 and 5 cascade; channels 0 and 3 never count phases.
      wire ph_en = (k == 0 || k == 3) ? 1'b0 : phase_en_in[PI];
      wire cas_en = (k == 2) ? cascade_en_in[0] : (k == 5) ? cascade_en_in[1] : 1'b0;
      wire cas_up = (k == 2) ? ovf_w[1] : (k == 5) ? ovf_w[4] : 1'b0;
      wire cas_dn = (k == 2) ? unf_w[1] : (k == 5) ? unf_w[4] : 1'b0;

      // Phases of channels 1 and 5 on pins a/b, of channels 2 and 4 on pins c/d.
      ptu_clk_src #(.SRC_MAP(MAP)) u_src (
        .clk_sel_in(clk_sel_in[3*k +: 3]),
        .presc_tick_in(presc_tick),
        .ext_rise_in(ext_rise),
        .phase_en_in(ph_en & run),
        .pa_in(ext_clock_pin_in[PA]),
        .pb_in(ext_clock_pin_in[PA+1]),
        .pa_q_in(ext_q_r[PA]),
        .pb_q_in(ext_q_r[PA+1]),
        .casc_en_in(cas_en),
        .casc_up_in(cas_up),
        .casc_dn_in(cas_dn),
        .up_out(up_w[k]),
        .dn_out(dn_w[k])
      );

      assign tick_w[k] = up_w[k] | dn_w[k];
      assign own_clr_w[k] = |clr_hit_w[B +: N];
      assign clr = own_clr_w[k] | (sync_en_in[k] & (csel == `PTU_CLR_SYNC) & grp_clr);
      assign cnt_wr = run & wr_en_in & (wr_sel_in == `PTU_SEL_CNT) &
                      ((wr_chan_in == k) | (sync_en_in[k] & wr_sync));
      assign ovf_w[k] = up_w[k] & ~clr & ~cnt_wr & (cnt_r == `PTU_CNT_MAX);
      assign unf_w[k] = dn_w[k] & ~clr & ~cnt_wr & (cnt_r == `PTU_CNT_ZERO);

      // Software load wins over clearing, clearing wins over counting.
      always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          cnt_r <= `PTU_CNT_RST;
          ovf_r <= 1'b0;
          unf_r <= 1'b0;
        end else begin
          ovf_r <= ovf_w[k];
          unf_r <= unf_w[k];
          if (cnt_wr) begin
            cnt_r <= wr_data_in;
          end else if (clr) begin
            cnt_r <= `PTU_CNT_ZERO;
          end else if (up_w[k]) begin
            cnt_r <= cnt_r + 16'h0001;
          end else if (dn_w[k]) begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
      end

      assign cnt_flat[16*k +: 16] = cnt_r;
      assign ovf_irq_out[k] = ovf_r;
      assign unf_r_w[k] = unf_r;
    end

    for (j = 0; j < 16; j = j + 1) begin : g_reg
      localparam [2:0] CH = ch_of(j);
      localparam integer LOC = j - base_of(j < 4 ? 0 : j < 6 ? 1 : j < 8 ? 2 :
                                           j < 12 ? 3 : j < 14 ? 4 : 5);
      localparam [2:0] CLR_CODE = LOC[2:0] + 3'h1;
      localparam BUF_CH = (CH == 3'h0) || (CH == 3'h3);
      localparam integer PJ = BUF_CH ? ((LOC < 2) ? j + 2 : j - 2) : j;
      localparam integer PW = (LOC % 2 == 0) ? j + 1 : j;
      reg [15:0] gr_r;
      reg pin_q_r;
      reg out_r;
      reg ev_r;
      wire buf_on;
      wire is_buf;
      wire pwm_sec;
      wire pwm_pri;
      wire wr_hit;
      wire [15:0] cnt;
      wire [1:0] act;
      wire [1:0] pact;
      wire [1:0] edg;

      assign buf_on = BUF_CH ? buf_en_in[(CH == 3'h3) ? 1 : 0] : 1'b0;
      assign is_buf = buf_on & (LOC >= 2);
      assign pwm_sec = pwm_en_in[CH] & (LOC % 2 == 1);
      assign pwm_pri = pwm_en_in[CH] & (LOC % 2 == 0);
      assign cnt = cnt_flat[16*CH +: 16];
      assign act = out_act_in[2*j +: 2];
      assign pact = out_act_in[2*PW +: 2];
      assign edg = cap_edge_in[2*j +: 2];
      assign wr_hit = run & wr_en_in & (wr_chan_in == CH) & (wr_sel_in == LOC);

      // Capture on the selected pin edges; buffers never capture or match.
      assign cap_w[j] = run & capture_en_in[j] & ~is_buf &
                        ((cc_pin_in[j] & ~pin_q_r & edg[`PTU_EDGE_RISE_BIT]) |
                         (~cc_pin_in[j] & pin_q_r & edg[`PTU_EDGE_FALL_BIT]));
      assign match_w[j] = ~capture_en_in[j] & ~is_buf & tick_w[CH] & (cnt == gr_r);
      assign clr_hit_w[j] = (match_w[j] | cap_w[j]) & (clr_sel_in[3*CH +: 3] == CLR_CODE);

      // Software write beats hardware updates in the same cycle.
      always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          gr_r <= `PTU_GR_RST;
          pin_q_r <= 1'b0;
          out_r <= 1'b0;
          ev_r <= 1'b0;
        end else begin
          pin_q_r <= cc_pin_in[j];
          ev_r <= match_w[j] | cap_w[j];
          if (wr_hit) begin
            gr_r <= wr_data_in;
          end else if (is_buf) begin
            if (cap_w[PJ]) begin
              gr_r <= gr_flat[16*PJ +: 16];
            end
          end else if (cap_w[j]) begin
            gr_r <= cnt;
          end else if (match_w[j] & buf_on) begin
            gr_r <= gr_flat[16*PJ +: 16];
          end
          if (match_w[j] & ~pwm_sec) begin
            case (act)
              `PTU_ACT_LOW: out_r <= 1'b0;
              `PTU_ACT_HIGH: out_r <= 1'b1;
              `PTU_ACT_TOG: out_r <= ~out_r;
              default: out_r <= out_r;
            endcase
          end else if (pwm_pri & match_w[PW]) begin
            case (pact)
              `PTU_ACT_LOW: out_r <= 1'b0;
              `PTU_ACT_HIGH: out_r <= 1'b1;
              `PTU_ACT_TOG: out_r <= ~out_r;
              default: out_r <= out_r;
            endcase
          end
        end
      end

      assign gr_flat[16*j +: 16] = gr_r;
      assign ev_r_w[j] = ev_r;
      assign cc_pin_out[j] = out_r;
      // In PWM the odd register only times the even pin, so its own pin floats.
      assign cc_pin_oe_out[j] = ~capture_en_in[j] & ~is_buf & ~pwm_sec &
                                ((act != `PTU_ACT_NONE) | pwm_pri);
    end
  endgenerate

  // Read mux; reads return zero while the unit is in module stop.
  always @* begin
    rd_nxt = 16'h0000;
    for (i = 0; i < 16; i = i + 1) begin
      if (rd_chan_in == ch_of(i) && rd_sel_in == i - base_of(ch_of(i))) begin
        rd_nxt = gr_flat[16*i +: 16];
      end
    end
    for (i = 0; i < 6; i = i + 1) begin
      if (rd_chan_in == i && rd_sel_in == `PTU_SEL_CNT) begin
        rd_nxt = cnt_flat[16*i +: 16];
      end
    end
    if (stop_r) begin
      rd_nxt = 16'h0000;
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      rd_data_out <= rd_nxt;
    end
  end

  // Event fan-out to interrupts, transfer requests and triggers.
  assign cc_irq_out = ev_r_w;
  assign unf_irq_out = {unf_r_w[5], unf_r_w[4], unf_r_w[2], unf_r_w[1]};
  assign dma_req_out = {ev_r_w[14], ev_r_w[12], ev_r_w[8],
                        ev_r_w[6], ev_r_w[4], ev_r_w[0]};
  assign adc_trig_out = dma_req_out;
  assign ppg_trig_out = {ev_r_w[9:8], ev_r_w[7:6], ev_r_w[5:4], ev_r_w[1:0]};

endmodule

// file: verif/ptu_checker_asserts.sv
// Purpose: Port-level assertions for the pulse timer unit.
// Assumes: One clock domain; bound to every instance of the top module.
// Notes: Sees ports only, so register contents are judged by the bench.
`timescale 1ns/1ns
module ptu_checker (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire module_stop_in,
  input wire [15:0] rd_data_out,
  input wire [5:0] pwm_en_in,
  input wire [3:0] phase_en_in,
  input wire [15:0] capture_en_in,
  input wire [15:0] cc_pin_in,
  input wire [15:0] cc_pin_out,
  input wire [15:0] cc_pin_oe_out,
  input wire [15:0] cc_irq_out,
  input wire [5:0] ovf_irq_out,
  input wire [3:0] unf_irq_out,
  input wire [5:0] dma_req_out,
  input wire [7:0] ppg_trig_out,
  input wire [5:0] adc_trig_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // Three stopped cycles flush the stop register and any event already in flight.
  sequence s_stopped;
    module_stop_in [*3];
  endsequence
  // A capture pin that holds still gives the edge detector nothing to see.
  sequence s_cap_still;
    (capture_en_in[0] && $stable(cc_pin_in[0])) [*3];
  endsequence

  a_dma_req_copy: assert property (dma_req_out == {cc_irq_out[14], cc_irq_out[12],
    cc_irq_out[8], cc_irq_out[6], cc_irq_out[4], cc_irq_out[0]})
    else $error("dma request differs from register A events");
  a_adc_trig_copy: assert property (adc_trig_out == dma_req_out)
    else $error("converter trigger differs from register A events");
  a_ppg_trig_map: assert property (ppg_trig_out == {cc_irq_out[9:8], cc_irq_out[7:6],
    cc_irq_out[5:4], cc_irq_out[1:0]})
    else $error("pulse generator trigger mapping wrong");
  a_stop_no_events: assert property (s_stopped |-> (cc_irq_out == 16'h0000)
    && (ovf_irq_out == 6'h00) && (unf_irq_out == 4'h0))
    else $error("event seen while halted");
  a_stop_read_zero: assert property (s_stopped |-> rd_data_out == 16'h0000)
    else $error("read data nonzero while halted");
  a_capture_no_edge: assert property (s_cap_still |-> !cc_irq_out[0])
    else $error("capture event without a pin edge");
  a_pin_needs_match: assert property (!pwm_en_in[0] && !$past(pwm_en_in[0])
    && $changed(cc_pin_out[0]) |-> cc_irq_out[0])
    else $error("pin changed without a compare match");
  a_capture_no_drive: assert property (capture_en_in[0] && $past(capture_en_in[0])
    && !pwm_en_in[0] && !$past(pwm_en_in[0]) |-> !cc_pin_oe_out[0])
    else $error("capture pin is being driven");
  a_unf_needs_phase: assert property (!phase_en_in[0] && !$past(phase_en_in[0])
    |-> !unf_irq_out[0])
    else $error("underflow on channel 1 without phase counting");
endmodule

bind pulse_timer_unit ptu_checker u_chk (.ref_clk_in, .rstn_in, .module_stop_in, .rd_data_out,
  .pwm_en_in, .phase_en_in, .capture_en_in, .cc_pin_in, .cc_pin_out, .cc_pin_oe_out,
  .cc_irq_out, .ovf_irq_out, .unf_irq_out, .dma_req_out, .ppg_trig_out, .adc_trig_out);

// file: verif/ptu_pin_model.sv
// Purpose: Outside world of the timer pins: encoder and capture sources.
// Assumes: Calls come from the bench; every change lands just after an edge.
// Notes: Levels are held at least two cycles so cycle-level edge detect sees them.
`timescale 1ns/1ns
module ptu_pin_model (
  input wire ref_clk_in,
  output reg [3:0] ext_pin_out,
  output reg [15:0] cc_drv_out
);
  reg [1:0] phase_r;

  // All pins start low and quiet.
  initial begin
    ext_pin_out = 4'h0;
    cc_drv_out = 16'h0000;
    phase_r = 2'h0;
  end

  // One encoder step on pins a and b; Gray order means one pin moves.
  task step(input reg fwd);
    begin
      @(posedge ref_clk_in);
      #1;
      phase_r = fwd ? phase_r + 2'h1 : phase_r - 2'h1;
      ext_pin_out[1:0] = {phase_r[1], phase_r[1] ^ phase_r[0]};
      repeat (2) @(posedge ref_clk_in);
    end
  endtask

  // Sets one capture pin level, then lets the edge settle.
  task set_pin(input integer idx, input reg lvl);
    begin
      @(posedge ref_clk_in);
      #1;
      cc_drv_out[idx] = lvl;
      repeat (2) @(posedge ref_clk_in);
    end
  endtask
endmodule

// file: verif/pulse_timer_unit_bench.sv
// Purpose: Self-checking bench of the pulse timer unit.
// Assumes: Pins come from ptu_pin_model; control bits are driven here.
// Notes: Idle channels select pin d or no source so their counters hold, except channel 3, which counts pin a in the phase test.
`timescale 1ns/1ns
module pulse_timer_unit_bench;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg stop = 1'b1;
  reg wr_en = 1'b0;
  reg [2:0] wr_chan = 3'h0;
  reg [2:0] wr_sel = 3'h0;
  reg [15:0] wr_data = 16'h0000;
  reg [2:0] rd_chan = 3'h0;
  reg [2:0] rd_sel = 3'h0;
  reg [17:0] clk_sel = 18'h3ffff;
  reg [17:0] clr_sel = 18'h00000;
  reg [5:0] sync_en = 6'h00;
  reg [5:0] pwm_en = 6'h00;
  reg [1:0] buf_en = 2'h0;
  reg [3:0] phase_en = 4'h0;
  reg [1:0] casc_en = 2'h0;
  reg [15:0] cap_en = 16'h0000;
  reg [31:0] out_act = 32'h00000000;
  reg [31:0] cap_edge = 32'h00000000;
  wire [3:0] ext_pin;
  wire [15:0] drv, cc_in, cc_out, cc_oe, cc_irq, rd_data;
  wire [5:0] ovf, dma, adc;
  wire [3:0] unf;
  wire [7:0] programmable_pulse_generator;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer unf_cnt = 0;

  // Each pin carries the timer's level while it drives, the outside level otherwise.
  assign cc_in = (cc_oe & cc_out) | (~cc_oe & drv);

  pulse_timer_unit u_dut (.ref_clk_in(ref_clk), .rstn_in(rstn), .module_stop_in(stop),
    .wr_en_in(wr_en), .wr_chan_in(wr_chan), .wr_sel_in(wr_sel), .wr_data_in(wr_data),
    .rd_chan_in(rd_chan), .rd_sel_in(rd_sel), .rd_data_out(rd_data), .clk_sel_in(clk_sel),
    .clr_sel_in(clr_sel), .sync_en_in(sync_en), .pwm_en_in(pwm_en), .buf_en_in(buf_en),
    .phase_en_in(phase_en), .cascade_en_in(casc_en), .capture_en_in(cap_en),
    .out_act_in(out_act), .cap_edge_in(cap_edge), .ext_clock_pin_in(ext_pin),
    .cc_pin_in(cc_in), .cc_pin_out(cc_out), .cc_pin_oe_out(cc_oe), .cc_irq_out(cc_irq),
    .ovf_irq_out(ovf), .unf_irq_out(unf), .dma_req_out(dma), .ppg_trig_out(programmable_pulse_generator),
    .adc_trig_out(adc));
  ptu_pin_model u_pins (.ref_clk_in(ref_clk), .ext_pin_out(ext_pin), .cc_drv_out(drv));

  // Free-running clock at 250 MHz.
  always #2 ref_clk = ~ref_clk;

  // The whole run needs well under a thousand cycles; a hang ends here.
  // Channel 1 underflow pulses last one cycle, so they are tallied here as they pass.
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (unf[0] === 1'b1)
      unf_cnt = unf_cnt + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task check_word(input string what, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task check_bit(input string what, input exp, input got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %s expected %b seen %b", what, exp, got);
      end
    end
  endtask

  // Steps just past a rising edge, where every input change is made.
  task tick;
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task wr(input [2:0] ch, input [2:0] sel, input [15:0] d);
    begin
      tick;
      wr_en = 1'b1;
      wr_chan = ch;
      wr_sel = sel;
      wr_data = d;
      tick;
      wr_en = 1'b0;
    end
  endtask

  // Read data is registered, so it is taken one edge after the address.
  task rd(input [2:0] ch, input [2:0] sel, output [15:0] d);
    begin
      tick;
      rd_chan = ch;
      rd_sel = sel;
      tick;
      d = rd_data;
    end
  endtask

  task t_stop;
    reg [15:0] d;
    begin
      wr(3'h1, 3'h0, 16'h1111);
      rd(3'h1, 3'h0, d);
      check_word("read while stopped", 16'h0000, d);
      stop = 1'b0;
      repeat (2) tick;
      rd(3'h1, 3'h0, d);
      check_word("write while stopped", 16'hffff, d);
      $display("test stop done");
    end
  endtask

  task t_rw;
    reg [15:0] d;
    begin
      wr(3'h1, 3'h1, 16'ha5c3);
      wr(3'h3, 3'h3, 16'h0f0f);
      wr(3'h1, 3'h2, 16'h1234);
      rd(3'h1, 3'h1, d);
      check_word("ch1 reg B", 16'ha5c3, d);
      rd(3'h3, 3'h3, d);
      check_word("ch3 reg D", 16'h0f0f, d);
      rd(3'h1, 3'h2, d);
      check_word("ch1 missing reg C", 16'h0000, d);
      $display("test rw done");
    end
  endtask

  task t_toggle;
    integer n;
    reg p;
    begin
      wr(3'h0, 3'h0, 16'h0002);
      clk_sel[2:0] = 3'h0;
      out_act[1:0] = 2'h3;
      clr_sel[2:0] = 3'h1;
      n = 0;
      while (cc_irq[0] !== 1'b1 && n < 20) begin
        tick;
        n = n + 1;
      end
      check_bit("first match", 1'b1, cc_irq[0]);
      p = cc_out[0];
      tick;
      check_bit("gap after match", 1'b0, cc_irq[0]);
      repeat (2) tick;
      check_bit("match period 3", 1'b1, cc_irq[0]);
      check_bit("pin toggled", ~p, cc_out[0]);
      check_bit("dma request", 1'b1, dma[0]);
      check_bit("converter trigger", 1'b1, adc[0]);
      check_bit("pulse trigger", 1'b1, programmable_pulse_generator[0]);
      check_bit("pin driven", 1'b1, cc_oe[0]);
      clk_sel[2:0] = 3'h7;
      out_act[1:0] = 2'h0;
      clr_sel[2:0] = 3'h0;
      $display("test toggle done");
    end
  endtask

  task t_capture;
    reg [15:0] d;
    begin
      cap_en[4] = 1'b1;
      cap_edge[9:8] = 2'h1;
      wr(3'h1, 3'h4, 16'h1234);
      u_pins.set_pin(4, 1'b1);
      wr(3'h1, 3'h4, 16'h4321);
      u_pins.set_pin(4, 1'b0);
      rd(3'h1, 3'h0, d);
      check_word("rising capture only", 16'h1234, d);
      $display("test capture done");
    end
  endtask

  task t_buffer;
    reg [15:0] d;
    begin
      buf_en = 2'h1;
      cap_en[0] = 1'b1;
      cap_edge[1:0] = 2'h1;
      wr(3'h0, 3'h4, 16'h0011);
      u_pins.set_pin(0, 1'b1);
      rd(3'h0, 3'h0, d);
      check_word("buffered capture", 16'h0011, d);
      rd(3'h0, 3'h2, d);
      check_word("buffer shift", 16'h0002, d);
      buf_en = 2'h0;
      $display("test buffer done");
    end
  endtask

  task t_phase;
    reg [15:0] d;
    integer i;
    begin
      phase_en[0] = 1'b1;
      wr(3'h1, 3'h4, 16'h8000);
      for (i = 0; i < 4; i = i + 1)
        u_pins.step(1'b1);
      rd(3'h1, 3'h4, d);
      check_word("four edges counted", 16'h8004, d);
      for (i = 0; i < 4; i = i + 1)
        u_pins.step(1'b0);
      rd(3'h1, 3'h4, d);
      check_word("reverse returns", 16'h8000, d);
      casc_en = 2'h1;
      wr(3'h2, 3'h4, 16'h0005);
      wr(3'h1, 3'h4, 16'h0000);
      unf_cnt = 0;
      u_pins.step(1'b0);
      rd(3'h1, 3'h4, d);
      check_word("ch1 wraps below zero", 16'hffff, d);
      check_word("ch1 underflow pulses", 16'h0001, unf_cnt[15:0]);
      rd(3'h2, 3'h4, d);
      check_word("cascade borrow", 16'h0004, d);
      casc_en = 2'h0;
      phase_en[0] = 1'b0;
      $display("test phase done");
    end
  endtask

  task t_ovf_sync;
    integer n;
    reg [15:0] d;
    begin
      wr(3'h3, 3'h4, 16'hfffd);
      clk_sel[11:9] = 3'h0;
      n = 0;
      while (ovf[3] !== 1'b1 && n < 10) begin
        tick;
        n = n + 1;
      end
      check_bit("ch3 overflow", 1'b1, ovf[3]);
      clk_sel[11:9] = 3'h7;
      sync_en = 6'h09;
      wr(3'h0, 3'h4, 16'h0055);
      rd(3'h3, 3'h4, d);
      check_word("group load", 16'h0055, d);
      sync_en = 6'h00;
      $display("test overflow sync done");
    end
  endtask

  // Channel 4 PWM: register A match drops the pin, register B match raises it and clears.
  task t_pwm;
    integer n;
    begin
      wr(3'h4, 3'h0, 16'h0001);
      wr(3'h4, 3'h1, 16'h0003);
      pwm_en[4] = 1'b1;
      out_act[27:24] = 4'h9;
      clr_sel[14:12] = 3'h2;
      clk_sel[14:12] = 3'h0;
      n = 0;
      while (cc_irq[13] !== 1'b1 && n < 20) begin
        tick;
        n = n + 1;
      end
      check_bit("pwm high at period end", 1'b1, cc_out[12]);
      check_bit("pwm pin driven", 1'b1, cc_oe[12]);
      check_bit("pwm timing pin floats", 1'b0, cc_oe[13]);
      repeat (2) tick;
      check_bit("pwm low after duty match", 1'b0, cc_out[12]);
      check_bit("ch4 converter trigger", 1'b1, adc[4]);
      clk_sel[14:12] = 3'h7;
      pwm_en[4] = 1'b0;
      out_act[27:24] = 4'h0;
      clr_sel[14:12] = 3'h0;
      $display("test pwm done");
    end
  endtask

  // Reset for four cycles, then every scenario in turn.
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    t_stop;
    t_rw;
    t_toggle;
    t_capture;
    t_buffer;
    t_phase;
    t_ovf_sync;
    t_pwm;
    end_of_test;
  end
endmodule
